// >>> logic/cnf_pkg.sv
// Shared constants and types for the channel input noise filter
package cnf_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int          CNF_CHANNELS    = 32;
    localparam int          CNF_PSC_W       = 3;
    localparam int          CNF_DIV_W       = 8;
    localparam int          CNF_FILL_MAX    = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0]  CNF_PSC_RST     = 3'h0;
    localparam logic        CNF_LEVEL_RST   = 1'b0;

    // ------------------------------------------------------------
    // Filter modes; code 2'b11 behaves as two-sample
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CNF_MODE_TWO   = 2'b00,
        CNF_MODE_THREE = 2'b01,
        CNF_MODE_CONT  = 2'b10
    } cnf_mode_t;

    localparam cnf_mode_t   CNF_MODE_RST    = CNF_MODE_TWO;

endpackage : cnf_pkg

// >>> logic/cnf_tick_if.sv
// Sampling strobes shared by the prescaler and every filter
`timescale 1ns/1ps
interface cnf_tick_if;
    logic filter_tick;
    logic half_tick;
    logic restart;

    modport src (output filter_tick, output half_tick, output restart);
    modport dst (input  filter_tick, input  half_tick, input  restart);
endinterface : cnf_tick_if

// >>> logic/cnf_prescaler.sv
// Filter clock prescaler and configuration change detector
`timescale 1ns/1ps
module cnf_prescaler (
    input  wire logic                        core_clk,
    input  wire logic                        sys_rst,
    input  wire cnf_pkg::cnf_mode_t          filter_mode_select,
    input  wire logic [cnf_pkg::CNF_PSC_W-1:0] filter_clock_prescale,
    cnf_tick_if.src                          tick
);
    import cnf_pkg::*;

    logic [CNF_DIV_W-1:0]           div_cnt_ff;
    logic [CNF_DIV_W-1:0]           nxt_div_cnt;
    logic [CNF_DIV_W-1:0]           div_mask;
    logic [CNF_PSC_W+1:0]           cfg_prev_ff;
    logic [CNF_PSC_W+1:0]           nxt_cfg_prev;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // RULE_06 power of two
    always_comb begin
        nxt_div_cnt  = div_cnt_ff + {{(CNF_DIV_W-1){1'b0}}, 1'b1};
        // RULE_07 code 000 samples every second clock
        div_mask     = CNF_DIV_W'((9'h002 << filter_clock_prescale) - 9'h001);
        nxt_cfg_prev = {filter_mode_select, filter_clock_prescale};
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_ff  <= '0;
            cfg_prev_ff <= {CNF_MODE_RST, CNF_PSC_RST};
        end else begin
            div_cnt_ff  <= nxt_div_cnt;
            cfg_prev_ff <= nxt_cfg_prev;
        end
    end

    // Every filter tick is also a half-rate tick, so continuous mode
    // closes its window on a sample it has seen
    // RULE_09 free-running phase decides borderline pulses
    assign tick.filter_tick = (div_cnt_ff & div_mask) == div_mask;
    assign tick.half_tick   = div_cnt_ff[0];
    // RULE_13 restart on change
    assign tick.restart     = nxt_cfg_prev != cfg_prev_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [8:0] gap_ff;
    logic       gap_ok_ff;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_ff    <= '0;
            gap_ok_ff <= 1'b0;
        end else if (tick.restart) begin
            gap_ff    <= '0;
            gap_ok_ff <= 1'b0;
        end else if (tick.filter_tick) begin
            gap_ff    <= '0;
            gap_ok_ff <= 1'b1;
        end else begin
            gap_ff    <= gap_ff + 9'h001;
        end
    end

    tick_period_a: assert property ( // RULE_06
        @(posedge core_clk) disable iff (sys_rst)
        tick.filter_tick && gap_ok_ff && !tick.restart
        |-> ({1'b0, gap_ff} + 10'h001) == (10'h002 << filter_clock_prescale))
        else $error("filter tick spacing differs from prescale divisor");

    half_rate_a: assert property ( // RULE_04
        @(posedge core_clk) disable iff (sys_rst)
        tick.half_tick |=> !tick.half_tick ##1 tick.half_tick)
        else $error("half-rate sample strobe not every second clock");

endmodule : cnf_prescaler

// >>> logic/cnf_filter.sv
// Synchronizer and three-mode noise filter for one input
`timescale 1ns/1ps
module cnf_filter (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic               pin_raw,
    input  wire cnf_pkg::cnf_mode_t filter_mode_select,
    cnf_tick_if.dst                 tick,
    output logic                    acc_level
);
    import cnf_pkg::*;

    logic       s1_ff, s2_ff, samp1_ff, samp2_ff, ref_ff, miss_ff, acc_ff;
    logic       nxt_samp1, nxt_samp2, nxt_ref, nxt_miss, nxt_acc;
    logic [1:0] fill_ff, nxt_fill, fill_inc;

    // ------------------------------------------------------------
    // Sampling and acceptance
    // ------------------------------------------------------------
    always_comb begin
        nxt_samp1 = samp1_ff;
        nxt_samp2 = samp2_ff;
        nxt_ref   = ref_ff;
        nxt_miss  = miss_ff;
        nxt_acc   = acc_ff;
        nxt_fill  = fill_ff;
        // RULE_08 count samples since restart
        fill_inc  = (fill_ff == 2'(CNF_FILL_MAX)) ? fill_ff : fill_ff + 2'h1;
        // RULE_13 forget old samples
        if (tick.restart) begin
            nxt_fill = 2'h0;
            nxt_miss = 1'b0;
            nxt_ref  = s2_ff;
        end else begin
            // RULE_01 mode select
            case (filter_mode_select)
                CNF_MODE_THREE: begin
                    if (tick.filter_tick) begin
                        nxt_samp1 = s2_ff;
                        nxt_samp2 = samp1_ff;
                        nxt_fill  = fill_inc;
                        // RULE_03 three agree
                        if (fill_ff == 2'(CNF_FILL_MAX) && s2_ff == samp1_ff &&
                            samp1_ff == samp2_ff) begin
                            nxt_acc = s2_ff;
                        end
                    end
                end
                CNF_MODE_CONT: begin
                    // RULE_05 any miss spoils period
                    if (tick.half_tick && s2_ff != ref_ff) begin
                        nxt_miss = 1'b1;
                    end
                    if (tick.filter_tick) begin
                        // RULE_04 whole period stable
                        if (fill_ff != 2'h0 && !miss_ff && s2_ff == ref_ff) begin
                            nxt_acc = ref_ff;
                        end
                        nxt_ref  = s2_ff;
                        nxt_miss = 1'b0;
                        nxt_fill = 2'h1;
                    end
                end
                default: begin
                    if (tick.filter_tick) begin
                        nxt_samp1 = s2_ff;
                        nxt_fill  = fill_inc;
                        // RULE_02 two agree
                        if (fill_ff != 2'h0 && s2_ff == samp1_ff) begin
                            nxt_acc = s2_ff;
                        end
                    end
                end
            endcase
        end
    end

    // RULE_10 synchronizer first
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_ff    <= CNF_LEVEL_RST;
            s2_ff    <= CNF_LEVEL_RST;
            samp1_ff <= CNF_LEVEL_RST;
            samp2_ff <= CNF_LEVEL_RST;
            ref_ff   <= CNF_LEVEL_RST;
            miss_ff  <= 1'b0;
            fill_ff  <= 2'h0;
            acc_ff   <= CNF_LEVEL_RST;
        end else begin
            s1_ff    <= pin_raw;
            s2_ff    <= s1_ff;
            samp1_ff <= nxt_samp1;
            samp2_ff <= nxt_samp2;
            ref_ff   <= nxt_ref;
            miss_ff  <= nxt_miss;
            fill_ff  <= nxt_fill;
            acc_ff   <= nxt_acc;
        end
    end

    // RULE_13 hold between updates
    assign acc_level = acc_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    two_accept_a: assert property ( // RULE_02
        @(posedge core_clk) disable iff (sys_rst)
        filter_mode_select == CNF_MODE_TWO && tick.filter_tick && !tick.restart &&
        fill_ff != 2'h0 && s2_ff == samp1_ff |=> acc_level == $past(s2_ff))
        else $error("two agreeing samples not accepted");

    three_hold_a: assert property ( // RULE_03
        @(posedge core_clk) disable iff (sys_rst)
        filter_mode_select == CNF_MODE_THREE && !(s2_ff == samp1_ff &&
        samp1_ff == samp2_ff) |=> $stable(acc_level))
        else $error("three-sample state moved without three equal samples");

    cont_block_a: assert property ( // RULE_05
        @(posedge core_clk) disable iff (sys_rst)
        filter_mode_select == CNF_MODE_CONT && miss_ff |=> $stable(acc_level))
        else $error("continuous mode accepted a noisy period");

endmodule : cnf_filter

// >>> logic/cnf_top.sv
// Channel and timebase-pin noise filters with transition detection
//
// Function
// RULE_01 - Three modes chosen by mode select
// RULE_02 - Two-sample: accept when two samples agree
// RULE_03 - Three-sample: accept when three samples agree
// RULE_04 - Continuous: half-rate samples, whole period stable
// RULE_05 - Continuous: any miss delays a full period
// RULE_06 - Filter clock is system clock over 2..256
// RULE_07 - Reset setting: reject <2, pass >=4 clocks
// RULE_08 - Detection needs two or three filter samples
// RULE_09 - Three-clock pulse may pass or fail
// RULE_10 - Synchronizer then filter on every input
// RULE_11 - Only accepted changes raise transition events
// RULE_12 - Angle mode: channel 0 uses timebase filter
// RULE_13 - Hold state; restart on setting change
`timescale 1ns/1ps
module cnf_top #(
    parameter int CHANNELS = cnf_pkg::CNF_CHANNELS
) (
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    input  wire cnf_pkg::cnf_mode_t            filter_mode_select,
    input  wire logic [cnf_pkg::CNF_PSC_W-1:0] filter_clock_prescale,
    input  wire logic                          angle_mode,
    input  wire logic                          external_timebase_clock_pin,
    input  wire logic [CHANNELS-1:0]           chan_pin,
    input  wire logic [CHANNELS-1:0]           chan_is_input,
    output logic [CHANNELS-1:0]                chan_level,
    output logic [CHANNELS-1:0]                chan_rise,
    output logic [CHANNELS-1:0]                chan_fall,
    output logic                               tb_level,
    output logic                               tb_rise,
    output logic                               tb_fall
);
    import cnf_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [CHANNELS-1:0]    ch_acc;
    logic [CHANNELS-1:0]    eff_level;
    logic                   tb_acc;

    logic [CHANNELS-1:0]    chan_level_ff;
    logic [CHANNELS-1:0]    nxt_chan_level;
    logic [CHANNELS-1:0]    chan_rise_ff;
    logic [CHANNELS-1:0]    nxt_chan_rise;
    logic [CHANNELS-1:0]    chan_fall_ff;
    logic [CHANNELS-1:0]    nxt_chan_fall;
    logic                   tb_level_ff;
    logic                   nxt_tb_level;
    logic                   tb_rise_ff;
    logic                   nxt_tb_rise;
    logic                   tb_fall_ff;
    logic                   nxt_tb_fall;

    cnf_tick_if             u_tick ();

    // ------------------------------------------------------------
    // Shared sampling clock
    // ------------------------------------------------------------
    // RULE_06 one prescaler for all
    cnf_prescaler u_prescaler (
        .core_clk              (core_clk),
        .sys_rst               (sys_rst),
        .filter_mode_select    (filter_mode_select),
        .filter_clock_prescale (filter_clock_prescale),
        .tick                  (u_tick.src)
    );

    // ------------------------------------------------------------
    // Timebase clock pin filter
    // ------------------------------------------------------------
    // RULE_10 timebase pin filtered
    cnf_filter u_tb_filter (
        .core_clk           (core_clk),
        .sys_rst            (sys_rst),
        .pin_raw            (external_timebase_clock_pin),
        .filter_mode_select (filter_mode_select),
        .tick               (u_tick.dst),
        .acc_level          (tb_acc)
    );

    // ------------------------------------------------------------
    // Channel filters
    // ------------------------------------------------------------
    // Filters run on every channel so that switching a channel to
    // input does not start from a stale level; events stay gated.
    // RULE_10 one filter per channel
    for (genvar gi = 0; gi < CHANNELS; gi++) begin : g_chan
        cnf_filter u_chan_filter (
            .core_clk           (core_clk),
            .sys_rst            (sys_rst),
            .pin_raw            (chan_pin[gi]),
            .filter_mode_select (filter_mode_select),
            .tick               (u_tick.dst),
            .acc_level          (ch_acc[gi])
        );
    end

    // ------------------------------------------------------------
    // Level selection and transition detection
    // ------------------------------------------------------------
    // Entering or leaving angle mode can swap channel 0's level and
    // so raise one event; software should ignore it.
    always_comb begin
        eff_level = ch_acc;
        // RULE_12 share timebase filter
        if (angle_mode) begin
            eff_level[0] = tb_acc;
        end
        nxt_chan_level = eff_level;
        // RULE_11 only accepted changes
        nxt_chan_rise  = eff_level & ~chan_level_ff & chan_is_input;
        nxt_chan_fall  = ~eff_level & chan_level_ff & chan_is_input;
        nxt_tb_level   = tb_acc;
        nxt_tb_rise    = tb_acc & ~tb_level_ff;
        nxt_tb_fall    = ~tb_acc & tb_level_ff;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_level_ff <= {CHANNELS{CNF_LEVEL_RST}};
            chan_rise_ff  <= '0;
            chan_fall_ff  <= '0;
            tb_level_ff   <= CNF_LEVEL_RST;
            tb_rise_ff    <= 1'b0;
            tb_fall_ff    <= 1'b0;
        end else begin
            chan_level_ff <= nxt_chan_level;
            chan_rise_ff  <= nxt_chan_rise;
            chan_fall_ff  <= nxt_chan_fall;
            tb_level_ff   <= nxt_tb_level;
            tb_rise_ff    <= nxt_tb_rise;
            tb_fall_ff    <= nxt_tb_fall;
        end
    end

    assign chan_level = chan_level_ff;
    assign chan_rise  = chan_rise_ff;
    assign chan_fall  = chan_fall_ff;
    assign tb_level   = tb_level_ff;
    assign tb_rise    = tb_rise_ff;
    assign tb_fall    = tb_fall_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // The top channel is never replaced in angle mode, so it is the
    // plain reference for the timing checks below.
    localparam int LAST = CHANNELS - 1;

    rise_cause_a: assert property ( // RULE_11
        @(posedge core_clk) disable iff (sys_rst)
        chan_rise[LAST] |-> chan_level[LAST] && !$past(chan_level[LAST]) &&
        $past(chan_is_input[LAST]))
        else $error("rising event without accepted rising level");

    fall_cause_a: assert property ( // RULE_11
        @(posedge core_clk) disable iff (sys_rst)
        chan_fall[LAST] |-> !chan_level[LAST] && $past(chan_level[LAST]) &&
        $past(chan_is_input[LAST]))
        else $error("falling event without accepted falling level");

    event_missed_a: assert property ( // RULE_11
        @(posedge core_clk) disable iff (sys_rst)
        chan_is_input[LAST] && ch_acc[LAST] && !chan_level[LAST]
        |=> chan_rise[LAST])
        else $error("accepted rising level raised no event");

    output_gate_a: assert property ( // RULE_10
        @(posedge core_clk) disable iff (sys_rst)
        !chan_is_input[LAST] |=> !chan_rise[LAST] && !chan_fall[LAST])
        else $error("event on a channel not configured as input");

    tick_only_a: assert property ( // RULE_13
        @(posedge core_clk) disable iff (sys_rst)
        $changed(chan_level[LAST]) |-> $past(u_tick.filter_tick, 2))
        else $error("channel level moved without a filter tick");

    restart_hold_a: assert property ( // RULE_13
        @(posedge core_clk) disable iff (sys_rst)
        u_tick.restart |=> ##1 $stable(chan_level[LAST]))
        else $error("level changed on a configuration change");

    angle_share_a: assert property ( // RULE_12
        @(posedge core_clk) disable iff (sys_rst)
        $past(angle_mode) |-> chan_level[0] == tb_level)
        else $error("channel 0 not following timebase filter in angle mode");

    own_filter_a: assert property ( // RULE_12
        @(posedge core_clk) disable iff (sys_rst)
        !$past(angle_mode) |-> chan_level[0] == $past(ch_acc[0]))
        else $error("channel 0 not using its own filter outside angle mode");

    tb_edge_a: assert property ( // RULE_11
        @(posedge core_clk) disable iff (sys_rst)
        tb_rise |-> tb_level && !$past(tb_level) && !tb_fall)
        else $error("timebase rising event without rising level");

    short_reject_a: assert property ( // RULE_07
        @(posedge core_clk) disable iff (sys_rst)
        filter_mode_select == CNF_MODE_TWO && filter_clock_prescale == CNF_PSC_RST &&
        $stable(filter_mode_select) && $stable(filter_clock_prescale) &&
        $changed(ch_acc[LAST])
        |-> ch_acc[LAST] == $past(chan_pin[LAST], 3) &&
            $past(chan_pin[LAST], 5) == $past(chan_pin[LAST], 3))
        else $error("single-clock pulse accepted at fastest filter clock");

endmodule : cnf_top

// >>> test/cnf_pin_src.sv
// Behavioural source of noisy channel and timebase pin levels
`timescale 1ns/1ps
module cnf_pin_src #(
    parameter int N = 4
) (
    input  wire logic    core_clk,
    output logic [N-1:0] chan_pin,
    output logic         tb_pin
);
    initial begin
        chan_pin = '0;
        tb_pin   = 1'b0;
    end
    // Pins move just after a rising edge; the filter sees them through its synchronizer
    task automatic step(input logic [N-1:0] cv, input logic tv);
        @(posedge core_clk);
        chan_pin <= cv;
        tb_pin   <= tv;
    endtask : step
endmodule : cnf_pin_src

// >>> test/tb.sv
// Self-checking bench for the channel input noise filter
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR %0t %s", $time, msg); end end
module tb;
    import cnf_pkg::*;
    localparam int NCH = 4;
    logic            core_clk;
    logic            sys_rst;
    cnf_mode_t       mode;
    logic [2:0]      psc;
    logic            angle_mode;
    logic [NCH-1:0]  chan_is_input;
    logic [NCH-1:0]  chan_pin;
    logic [NCH-1:0]  chan_level;
    logic [NCH-1:0]  chan_rise;
    logic [NCH-1:0]  chan_fall;
    logic            tb_pin;
    logic            tb_level;
    logic            tb_rise;
    logic            tb_fall;
    int              mismatches;
    int              cmp_count;
    int              cyc;
    int              n_r1;
    int              n_f1;
    int              n_r2;
    int              n_r0;
    int              n_tr;
    int              n_tf;

    cnf_top #(.CHANNELS(NCH)) DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .filter_mode_select(mode),
        .filter_clock_prescale(psc), .angle_mode(angle_mode),
        .external_timebase_clock_pin(tb_pin), .chan_pin(chan_pin),
        .chan_is_input(chan_is_input), .chan_level(chan_level), .chan_rise(chan_rise),
        .chan_fall(chan_fall), .tb_level(tb_level), .tb_rise(tb_rise), .tb_fall(tb_fall)
    );
    cnf_pin_src #(.N(NCH)) src (.core_clk(core_clk), .chan_pin(chan_pin), .tb_pin(tb_pin));

    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    // ------------------------------------------------------------
    // Event counters, sampled where outputs are settled
    // ------------------------------------------------------------
    always @(negedge core_clk) begin
        if (chan_rise[1] === 1'b1) n_r1++;
        if (chan_fall[1] === 1'b1) n_f1++;
        if (chan_rise[2] === 1'b1) n_r2++;
        if (chan_rise[0] === 1'b1) n_r0++;
        if (tb_rise === 1'b1) n_tr++;
        if (tb_fall === 1'b1) n_tf++;
    end

    task automatic clr();
        n_r1 = 0; n_f1 = 0; n_r2 = 0; n_r0 = 0; n_tr = 0; n_tf = 0;
    endtask : clr

    task automatic run(input logic [NCH-1:0] cv, input logic tv, input int n);
        repeat (n) src.step(cv, tv);
    endtask : run

    task automatic cfg(input cnf_mode_t m, input logic [2:0] p);
        @(posedge core_clk);
        mode <= m;
        psc  <= p;
    endtask : cfg

    // Exp below zero: either outcome is fine, but rise and fall must pair
    task automatic pulse_test(input cnf_mode_t m, input int code, input int w, input int exp);
        int d;
        d = 2 << code;
        cfg(m, code[2:0]);
        run('0, 1'b0, 6 * d + 10);
        clr();
        `CHK(chan_level[1], 1'b0, "level not idle")
        run('1, 1'b0, w);
        run('0, 1'b0, 8 * d + 10);
        if (exp >= 0) begin
            `CHK(n_r1, exp, "rise count")
            `CHK(n_f1, exp, "fall count")
        end else
            `CHK(n_f1, n_r1, "unpaired edges")
        `CHK(n_r2, 0, "event on non-input channel")
    endtask : pulse_test

    task automatic t_pulses();
        cnf_mode_t ml[3];
        int        d;
        ml = '{CNF_MODE_TWO, CNF_MODE_THREE, CNF_MODE_CONT};
        // every mode over every prescale code
        foreach (ml[k]) for (int c = 0; c < 8; c++) begin
            d = 2 << c;
            pulse_test(ml[k], c, (ml[k] == CNF_MODE_THREE) ? 3 * d : 2 * d, 1);
            pulse_test(ml[k], c, (ml[k] == CNF_MODE_THREE) ? 2 * d : d - 1, 0);
        end
        // reset divisor: three either way; then code 2'b11 at divisor 4 passes as two-sample
        pulse_test(CNF_MODE_TWO, 0, 3, -1);
        pulse_test(cnf_mode_t'(2'b11), 1, 8, 1);
        $display("test pulses done");
    endtask : t_pulses

    // Rise aligned to the free prescaler phase; g < 0 means no glitch
    task automatic lat(input int g, output int l);
        logic v;
        run('0, 1'b0, 110);
        while (cyc % 16 != 0) src.step('0, 1'b0);
        l = 999;
        for (int i = 0; i < 120; i++) begin
            v = !(g >= 0 && i >= g && i < g + 2);
            src.step({NCH{v}}, 1'b0);
            @(negedge core_clk);
            if (chan_level[1] === 1'b1) begin
                l = i;
                break;
            end
        end
    endtask : lat

    task automatic t_cont_glitch();
        int l0;
        int l1;
        cfg(CNF_MODE_CONT, 3'h3);
        lat(-1, l0);
        lat(l0 - 14, l1);
        // clean latency within two filter periods plus pipeline
        `CHK(l0 <= 40, 1'b1, "continuous latency too long")
        // a sampled glitch costs a whole filter period
        `CHK(l1 >= l0 + 16 && l1 <= l0 + 32, 1'b1, "glitch delay")
        run('0, 1'b0, 110);
        $display("test continuous glitch done");
    endtask : t_cont_glitch

    task automatic t_restart();
        cfg(CNF_MODE_TWO, 3'h0);
        run('0, 1'b0, 20);
        clr();
        // mode flipping every cycle keeps forgetting samples
        for (int i = 0; i < 40; i++) begin
            src.step('1, 1'b0);
            mode <= cnf_mode_t'((i % 2 == 0) ? 2'b11 : 2'b00);
        end
        `CHK(n_r1, 0, "accepted during restart")
        @(posedge core_clk);
        mode <= CNF_MODE_TWO;
        run('1, 1'b0, 12);
        `CHK(n_r1, 1, "no accept after restart")
        `CHK(chan_level[2], 1'b1, "non-input level")
        run('0, 1'b0, 20);
        $display("test restart done");
    endtask : t_restart

    task automatic t_angle();
        cfg(CNF_MODE_TWO, 3'h0);
        angle_mode <= 1'b1;
        run('0, 1'b0, 20);
        clr();
        run('0, 1'b1, 20);
        // channel 0 follows the timebase pin filter
        `CHK(chan_level[0], 1'b1, "ch0 not on timebase")
        `CHK(n_r0, 1, "ch0 rise")
        `CHK(n_tr, 1, "timebase rise")
        `CHK(tb_level, 1'b1, "timebase level")
        @(posedge core_clk);
        angle_mode <= 1'b0;
        run('0, 1'b1, 10);
        `CHK(chan_level[0], 1'b0, "ch0 own filter")
        run('0, 1'b0, 20);
        `CHK(n_tf, 1, "timebase fall")
        `CHK(tb_level, 1'b0, "timebase level low")
        $display("test angle done");
    endtask : t_angle

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (90000) @(posedge core_clk);
        mismatches++;
        test_done();
    end

    initial begin
        mismatches = 0;
        cmp_count = 0;
        cyc = 0;
        clr();
        sys_rst = 1'b1;
        mode = CNF_MODE_RST;
        psc = CNF_PSC_RST;
        angle_mode = 1'b0;
        chan_is_input = 4'b1011;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        `CHK(chan_level, 4'h0, "reset level")
        `CHK({chan_rise, tb_level, tb_rise}, 6'h00, "reset events")
        $display("test reset done");
        t_restart();
        t_angle();
        t_cont_glitch();
        t_pulses();
        test_done();
    end
endmodule : tb
